/* File: rtl/ssc_pkg.sv */
// Shared constants for the sequencer last-step configuration bank
package ssc_pkg;

  // Bus widths
  localparam int unsigned ADDR_W = 32;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned REG_W  = 16;

  // Register indices as printed; byte address is four times the index
  localparam logic [7:0]  IDX_STEP_CFG  = 8'h9F;
  localparam logic [7:0]  IDX_SPARE     = 8'hA0;
  localparam logic [7:0]  IDX_CRC       = 8'hBE;
  localparam logic [7:0]  IDX_STATUS    = 8'hC8;
  localparam int unsigned IDX_LSB       = 2;
  localparam int unsigned IDX_W         = 8;

  // Reset values
  localparam logic [15:0] RST_STEP_CFG  = 16'h000F;
  localparam logic [15:0] RST_SPARE     = 16'h0210;
  localparam logic [15:0] RST_CRC       = 16'h0000;

  // Step register fields
  localparam int unsigned STEP_EN_BIT   = 15;
  localparam int unsigned GAIN_HI       = 14;
  localparam int unsigned GAIN_LO       = 13;
  localparam int unsigned NEG_BIT       = 4;
  localparam int unsigned POS_HI        = 3;
  localparam int unsigned POS_LO        = 0;
  localparam logic [15:0] STEP_WMASK    = 16'hE01F;

  // Spare register: writable fields and fixed reserved pattern
  localparam logic [15:0] SPARE_WMASK   = 16'h0C30;
  localparam logic [15:0] SPARE_FIXED   = 16'h0200;

  // Positive input codes
  localparam logic [3:0]  POS_TEMP      = 4'h8;
  localparam logic [3:0]  POS_GND_SHORT = 4'h9;
  localparam logic [3:0]  POS_TEST_DAC  = 4'hB;
  localparam int unsigned INTERNAL_BIT  = 3;
  localparam int unsigned NUM_EXT       = 8;

  // Gain codes and factors
  localparam logic [1:0]  GAIN_CODE_X1  = 2'h0;
  localparam logic [1:0]  GAIN_CODE_X2  = 2'h1;
  localparam logic [2:0]  GAIN_X1       = 3'h1;
  localparam logic [2:0]  GAIN_X2       = 3'h2;
  localparam logic [2:0]  GAIN_X4       = 3'h4;

  // Internal source classes
  typedef enum logic [1:0] {
    SSC_SRC_TEMP,
    SSC_SRC_GND_SHORT,
    SSC_SRC_TEST_DAC,
    SSC_SRC_SUPPLY
  } ssc_src_e;

  // AHB-Lite encodings
  localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0]  HSIZE_WORD    = 3'h2;
  localparam logic        HRESP_OKAY    = 1'h0;

endpackage

/* File: rtl/ssc_step_decode.sv */
// Registered decode of the last step's stored fields into mux and gain controls
`timescale 1ns/100ps
`default_nettype none

module ssc_step_decode (
  // Clock and reset
  input  wire  logic                   hclk,
  input  wire  logic                   hresetn,
  // Stored step fields
  input  wire  logic [15:0]            step_cfg,
  // Decoded controls
  output var   logic                   step_active,
  output var   logic [2:0]             gain_factor,
  output var   logic                   neg_to_ext_seven,
  output var   logic                   neg_auto,
  output var   logic [ssc_pkg::NUM_EXT-1:0] pos_ext_onehot,
  output var   logic                   pos_internal,
  output var   ssc_pkg::ssc_src_e      internal_src
);
  import ssc_pkg::*;

  logic [1:0]         gain_code;
  logic [3:0]         pos_code;
  logic               auto_sel;
  logic [2:0]         gain_nxt;
  logic [NUM_EXT-1:0] onehot_nxt;
  ssc_src_e           src_nxt;

  assign gain_code = step_cfg[GAIN_HI:GAIN_LO];
  assign pos_code  = step_cfg[POS_HI:POS_LO];

  // [R05] Upper codes are internal
  assign auto_sel  = pos_code[INTERNAL_BIT];

  // [R02] Gain code mapping
  assign gain_nxt  = (gain_code == GAIN_CODE_X1) ? GAIN_X1 :
                     (gain_code == GAIN_CODE_X2) ? GAIN_X2 : GAIN_X4;

  // [R04] One external input per code
  genvar gi;
  generate
    for (gi = 0; gi < NUM_EXT; gi++) begin : g_ext
      assign onehot_nxt[gi] = !auto_sel && (pos_code[INTERNAL_BIT-1:0] == INTERNAL_BIT'(gi));
    end
  endgenerate

  // [R05] Internal source class
  assign src_nxt = (pos_code == POS_TEMP)      ? SSC_SRC_TEMP :
                   (pos_code == POS_GND_SHORT) ? SSC_SRC_GND_SHORT :
                   (pos_code == POS_TEST_DAC)  ? SSC_SRC_TEST_DAC : SSC_SRC_SUPPLY;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      step_active      <= 1'b0;
      gain_factor      <= GAIN_X1;
      neg_to_ext_seven <= 1'b0;
      neg_auto         <= 1'b1;
      pos_ext_onehot   <= '0;
      pos_internal     <= 1'b1;
      internal_src     <= SSC_SRC_SUPPLY;
    end else begin
      // [R01] Disabled step is skipped
      step_active      <= step_cfg[STEP_EN_BIT];
      gain_factor      <= gain_nxt;
      // [R06] Stored negative select ignored
      neg_to_ext_seven <= step_cfg[NEG_BIT] && !auto_sel;
      neg_auto         <= auto_sel;
      pos_ext_onehot   <= onehot_nxt;
      pos_internal     <= auto_sel;
      internal_src     <= src_nxt;
    end
  end

endmodule

`default_nettype wire

/* File: rtl/ssc_bank.sv */
// AHB-Lite register bank for the converter sequencer's last step and spare bits
`timescale 1ns/100ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// What this block does
// [R01] Step-enable bit 15 turns the last sequencer step on at 1 and skips it at 0.
// [R02] Gain code in bits 14:13 gives gain 1 for 00b, 2 for 01b and 4 for 10b or 11b.
// [R03] Bit 4 ties the negative input to analog ground at 0 or to external input seven at 1.
// [R04] Positive codes 0000b to 0111b pick external inputs zero to seven in order.
// [R05] Codes from 1000b pick internal sources and choose the negative input automatically.
// [R06] With automatic negative selection the stored negative select bit is ignored.
// [R07] The step register sits at index 9Fh and resets to 000Fh.
// [R08] The spare register keeps two writable 2-bit fields at 11:10 and 5:4 with no effect.
// [R09] The spare register sits at index A0h and resets to 0210h.
// [R10] A 16-bit writable expected-CRC register for section two sits at index BEh.
// [R11] Reserved bits ignore writes and read fixed values, 1000b in spare bits 9:6 and zero elsewhere.
module ssc_bank (
  // Clock and reset
  input  wire  logic                          hclk,
  input  wire  logic                          hresetn,
  // AHB-Lite slave
  input  wire  logic                          hsel,
  input  wire  logic [ssc_pkg::ADDR_W-1:0]    haddr,
  input  wire  logic [1:0]                    htrans,
  input  wire  logic                          hwrite,
  input  wire  logic [2:0]                    hsize,
  input  wire  logic                          hready,
  input  wire  logic [ssc_pkg::DATA_W-1:0]    hwdata,
  output var   logic [ssc_pkg::DATA_W-1:0]    hrdata,
  output var   logic                          hreadyout,
  output var   logic                          hresp,
  // Step controls to the converter sequencer
  output var   logic                          last_step_enable,
  output var   logic [2:0]                    last_step_gain_factor,
  output var   logic                          last_step_neg_ext_seven,
  output var   logic                          last_step_neg_auto,
  output var   logic [ssc_pkg::NUM_EXT-1:0]   last_step_pos_ext,
  output var   logic                          last_step_pos_internal,
  output var   ssc_pkg::ssc_src_e             last_step_internal_src,
  // Raw stored field for the mux driver
  output var   logic [3:0]                    last_step_pos_input_sel,
  // Expected CRC to the section checker
  output var   logic [ssc_pkg::REG_W-1:0]     section_two_expected_crc
);
  import ssc_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // Storage

  logic [REG_W-1:0] seq_last_step_config_r;
  logic [REG_W-1:0] seq_last_step_config_nxt;
  logic [REG_W-1:0] crc_check_spare_bits_r;
  logic [REG_W-1:0] crc_check_spare_bits_nxt;
  logic [REG_W-1:0] expected_crc_r;
  logic [REG_W-1:0] expected_crc_nxt;

  //////////////////////////////////////////////////////////////////////////////
  // Address phase capture

  logic             wr_pend_r;
  logic [IDX_W-1:0] wr_idx_r;
  logic [DATA_W-1:0] hrdata_r;
  logic             addr_take;
  logic             wr_take;
  logic             rd_take;
  logic [IDX_W-1:0] addr_idx;
  logic             addr_in_range;

  assign addr_take     = hsel && hready && (htrans == HTRANS_NONSEQ);
  assign addr_idx      = haddr[IDX_LSB +: IDX_W];
  // Anything beyond the index field or off word alignment is unmapped
  assign addr_in_range = (haddr[ADDR_W-1:IDX_LSB+IDX_W] == '0) && (haddr[IDX_LSB-1:0] == '0);
  // Only whole-word writes change state; narrower ones are dropped quietly
  assign wr_take       = addr_take && hwrite && (hsize == HSIZE_WORD) && addr_in_range;
  assign rd_take       = addr_take && !hwrite;

  //////////////////////////////////////////////////////////////////////////////
  // Data phase write decode

  logic             wr_step;
  logic             wr_spare;
  logic             wr_crc;
  logic [REG_W-1:0] wdata16;

  assign wdata16  = hwdata[REG_W-1:0];

  // [R07] Step register index
  assign wr_step  = wr_pend_r && (wr_idx_r == IDX_STEP_CFG);
  // [R09] Spare register index
  assign wr_spare = wr_pend_r && (wr_idx_r == IDX_SPARE);
  // [R10] Expected CRC index
  assign wr_crc   = wr_pend_r && (wr_idx_r == IDX_CRC);

  // [R11] Step reserved bits hold zero
  assign seq_last_step_config_nxt = wr_step ? (wdata16 & STEP_WMASK) : seq_last_step_config_r;

  // [R08] Spare fields store only
  assign crc_check_spare_bits_nxt = wr_spare ? ((wdata16 & SPARE_WMASK) | SPARE_FIXED)
                                             : crc_check_spare_bits_r;

  // [R10] Whole word writable
  assign expected_crc_nxt         = wr_crc ? wdata16 : expected_crc_r;

  //////////////////////////////////////////////////////////////////////////////
  // Read mux

  // Width of the packed decoded-state view
  localparam int unsigned STATUS_W = 18;

  logic [DATA_W-1:0] status_word;
  logic [DATA_W-1:0] rd_word;
  logic              rd_step;
  logic              rd_spare;
  logic              rd_crc;
  logic              rd_status;

  // Decoded state seen by the sequencer, for software inspection
  assign status_word = {{(DATA_W-STATUS_W){1'b0}},
                        last_step_enable,
                        last_step_neg_auto,
                        last_step_neg_ext_seven,
                        last_step_pos_internal,
                        last_step_internal_src,
                        last_step_gain_factor,
                        1'b0,
                        last_step_pos_ext};

  assign rd_step   = addr_in_range && (addr_idx == IDX_STEP_CFG);
  assign rd_spare  = addr_in_range && (addr_idx == IDX_SPARE);
  assign rd_crc    = addr_in_range && (addr_idx == IDX_CRC);
  assign rd_status = addr_in_range && (addr_idx == IDX_STATUS);

  // Step, spare and CRC reads use next values so a write just before is seen at once; status reads use the registered decoded outputs
  always_comb begin
    if (rd_step) begin
      rd_word = {{(DATA_W-REG_W){1'b0}}, seq_last_step_config_nxt};
    end else if (rd_spare) begin
      rd_word = {{(DATA_W-REG_W){1'b0}}, crc_check_spare_bits_nxt};
    end else if (rd_crc) begin
      rd_word = {{(DATA_W-REG_W){1'b0}}, expected_crc_nxt};
    end else if (rd_status) begin
      rd_word = status_word;
    end else begin
      rd_word = '0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Bus-side flops

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_idx_r  <= '0;
    end else if (hready) begin
      wr_pend_r <= wr_take;
      wr_idx_r  <= addr_idx;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_r <= '0;
    end else if (rd_take) begin
      hrdata_r <= rd_word;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b0;
      hresp     <= HRESP_OKAY;
    end else begin
      // Zero wait states; low only during reset
      hreadyout <= 1'b1;
      hresp     <= HRESP_OKAY;
    end
  end

  assign hrdata = hrdata_r;

  //////////////////////////////////////////////////////////////////////////////
  // Register flops

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      // [R07] Step register reset
      seq_last_step_config_r <= RST_STEP_CFG;
      // [R09] Spare register reset
      crc_check_spare_bits_r <= RST_SPARE;
      expected_crc_r         <= RST_CRC;
    end else begin
      seq_last_step_config_r <= seq_last_step_config_nxt;
      crc_check_spare_bits_r <= crc_check_spare_bits_nxt;
      expected_crc_r         <= expected_crc_nxt;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      last_step_pos_input_sel  <= RST_STEP_CFG[POS_HI:POS_LO];
      section_two_expected_crc <= RST_CRC;
    end else begin
      last_step_pos_input_sel  <= seq_last_step_config_r[POS_HI:POS_LO];
      section_two_expected_crc <= expected_crc_r;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Step decode

  // [R03] Negative input select path
  ssc_step_decode u_decode (
    .hclk             (hclk),
    .hresetn          (hresetn),
    .step_cfg         (seq_last_step_config_r),
    .step_active      (last_step_enable),
    .gain_factor      (last_step_gain_factor),
    .neg_to_ext_seven (last_step_neg_ext_seven),
    .neg_auto         (last_step_neg_auto),
    .pos_ext_onehot   (last_step_pos_ext),
    .pos_internal     (last_step_pos_internal),
    .internal_src     (last_step_internal_src)
  );

endmodule

`default_nettype wire

/* File: verification/ssc_bank_props.sv */
// Concurrent checks on the last-step configuration bank ports
`timescale 1ns/100ps
`default_nettype none
module ssc_bank_props (
  // Clock, reset and bus
  input wire logic                  hclk,
  input wire logic                  hresetn,
  input wire logic                  hsel,
  input wire logic [31:0]           haddr,
  input wire logic [1:0]            htrans,
  input wire logic                  hwrite,
  input wire logic [2:0]            hsize,
  input wire logic                  hready,
  input wire logic [31:0]           hwdata,
  input wire logic [31:0]           hrdata,
  // Decoded step controls
  input wire logic                  last_step_enable,
  input wire logic [2:0]            last_step_gain_factor,
  input wire logic                  last_step_neg_ext_seven,
  input wire logic                  last_step_neg_auto,
  input wire logic [7:0]            last_step_pos_ext,
  input wire logic                  last_step_pos_internal,
  input wire ssc_pkg::ssc_src_e     last_step_internal_src,
  input wire logic [3:0]            last_step_pos_input_sel,
  input wire logic [15:0]           section_two_expected_crc
);
  import ssc_pkg::*;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  ////////////////////////////////////////////////////////////////////////////////
  logic       rd_q;
  logic       wr_q;
  logic [7:0] idx_q;
  wire        hit = hsel && hready && htrans == HTRANS_NONSEQ && haddr[31:10] == 22'h0 && haddr[1:0] == 2'h0;
  wire        wr_step = wr_q && idx_q == IDX_STEP_CFG;
  wire        wr_crc = wr_q && idx_q == IDX_CRC;
  wire [1:0]  src_exp = (last_step_pos_input_sel == POS_TEMP) ? 2'h0 :
                        (last_step_pos_input_sel == POS_GND_SHORT) ? 2'h1 :
                        (last_step_pos_input_sel == POS_TEST_DAC) ? 2'h2 : 2'h3;
  // Data phase follows the taken address phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_q <= 1'b0;
      wr_q <= 1'b0;
      idx_q <= 8'h00;
    end else begin
      rd_q <= hit && !hwrite;
      wr_q <= hit && hwrite && hsize == HSIZE_WORD;
      idx_q <= haddr[9:2];
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  a_reset_values:
    assert property (!$past(hresetn) |-> !last_step_enable && last_step_pos_input_sel == 4'hF
      && last_step_gain_factor == GAIN_X1) else $error("step outputs not at reset values");
  a_enable_follows:
    assert property (wr_step |-> ##2 last_step_enable == $past(hwdata[15], 2)) else $error("enable wrong");
  a_gain_decode:
    assert property (wr_step |-> ##2 last_step_gain_factor == ($past(hwdata[14], 2) ? GAIN_X4 :
      $past(hwdata[13], 2) ? GAIN_X2 : GAIN_X1)) else $error("gain factor wrong");
  a_neg_select:
    assert property (wr_step |-> ##2 last_step_neg_ext_seven == ($past(hwdata[4], 2) && !$past(hwdata[3], 2)))
      else $error("negative input wrong");
  a_pos_code_follows:
    assert property (wr_step |-> ##2 last_step_pos_input_sel == $past(hwdata[3:0], 2)) else $error("pos code wrong");
  a_pos_ext_onehot:
    assert property (!last_step_pos_input_sel[3] |-> last_step_pos_ext == 8'h01 << last_step_pos_input_sel
      && !last_step_pos_internal) else $error("external input select wrong");
  a_internal_source:
    assert property (last_step_pos_input_sel[3] |-> last_step_pos_ext == 8'h00 && last_step_pos_internal
      && last_step_internal_src == src_exp) else $error("internal source wrong");
  a_auto_neg_wins:
    assert property (last_step_neg_auto == last_step_pos_input_sel[3] && !(last_step_neg_auto && last_step_neg_ext_seven))
      else $error("automatic negative select wrong");
  a_crc_follows:
    assert property (wr_crc |-> ##2 section_two_expected_crc == $past(hwdata[15:0], 2)) else $error("crc copy wrong");
  a_spare_reserved:
    assert property (rd_q && idx_q == IDX_SPARE |-> hrdata[31:12] == 20'h0 && hrdata[9:6] == 4'h8
      && hrdata[3:0] == 4'h0) else $error("spare reserved bits wrong");
  a_step_reserved:
    assert property (rd_q && idx_q == IDX_STEP_CFG |-> hrdata[31:16] == 16'h0 && hrdata[12:5] == 8'h0)
      else $error("step reserved bits wrong");
  c_step_write: cover property (wr_step);
  c_crc_write: cover property (wr_crc);
  c_spare_read: cover property (rd_q && idx_q == IDX_SPARE);
endmodule
bind ssc_bank ssc_bank_props i_ssc_bank_props (
  .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hready, .hwdata, .hrdata,
  .last_step_enable, .last_step_gain_factor, .last_step_neg_ext_seven, .last_step_neg_auto,
  .last_step_pos_ext, .last_step_pos_internal, .last_step_internal_src, .last_step_pos_input_sel,
  .section_two_expected_crc
);
`default_nettype wire

/* File: verification/test_sequencer_step_config.sv */
// Directed bench for the last-step configuration bank
`timescale 1ns/100ps
`default_nettype none
module test_sequencer_step_config;
  import ssc_pkg::*;
  // Byte addresses are four times the register index
  localparam logic [31:0] A_STEP  = 32'h0000027C;
  localparam logic [31:0] A_SPARE = 32'h00000280;
  localparam logic [31:0] A_CRC   = 32'h000002F8;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize, last_step_gain_factor, g;
  logic        last_step_enable, last_step_neg_ext_seven, last_step_neg_auto, last_step_pos_internal;
  logic [7:0]  last_step_pos_ext;
  logic [3:0]  last_step_pos_input_sel;
  logic [15:0] section_two_expected_crc, v;
  ssc_src_e    last_step_internal_src;
  int          fails, n_tests;
  ssc_bank i_ssc_bank (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hready(hreadyout), .hwdata, .hrdata,
    .hreadyout, .hresp, .last_step_enable, .last_step_gain_factor, .last_step_neg_ext_seven,
    .last_step_neg_auto, .last_step_pos_ext, .last_step_pos_internal, .last_step_internal_src,
    .last_step_pos_input_sel, .section_two_expected_crc
  );
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Bounded wait for ready at a rising edge
  task automatic wait_ready();
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 20) begin
        fails++;
        end_of_test();
      end
      @(posedge hclk);
    end
  endtask
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d, input logic [2:0] sz);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    hsize <= sz;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready();
    rd = hrdata;
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, HSIZE_WORD);
  endtask
  task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0, HSIZE_WORD);
    check(rd, exp);
  endtask
  // Decoded outputs land one edge after the register
  task automatic settle();
    repeat (2) @(posedge hclk);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end
  initial begin
    {hresetn, hsel, hwrite, haddr, htrans, hsize, hwdata} = '0;
    fails = 0;
    n_tests = 0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    wait_ready();
    rd_chk(A_STEP, 32'h000F); // reset value
    rd_chk(A_SPARE, 32'h0210); // reset value
    rd_chk(A_CRC, 32'h0); // reset value
    check(last_step_internal_src, SSC_SRC_SUPPLY); // supply source at reset
    wr(A_STEP, 32'hFFFFFFFF);
    rd_chk(A_STEP, 32'hE01F); // reserved bits fixed
    settle();
    check(last_step_neg_ext_seven, 1'b0); // stored bit ignored
    wr(A_SPARE, 32'hFFFFFFFF);
    rd_chk(A_SPARE, 32'h0E30); // spare fields stored
    wr(A_SPARE, 32'h0);
    rd_chk(A_SPARE, 32'h0200); // fixed pattern kept
    settle();
    check({last_step_enable, last_step_pos_input_sel}, 5'h1F); // no effect on step
    wr(A_CRC, 32'hFFFFA5C3);
    settle();
    check(section_two_expected_crc, 32'hA5C3); // value passed on
    rd_chk(A_CRC, 32'hA5C3); // value read back
    xfer(1'b1, A_STEP, 32'h0, 3'h1);
    check(hresp, HRESP_OKAY);
    rd_chk(A_STEP, 32'hE01F); // halfword write ignored
    wr(32'h00000284, 32'hFFFF);
    rd_chk(32'h00000284, 32'h0); // unmapped reads zero
    for (int k = 0; k < 16; k++) begin
      v = {k[0], k[1:0], 8'h00, 1'b1, k[3:0]};
      g = (k % 4 == 0) ? GAIN_X1 : (k % 4 == 1) ? GAIN_X2 : GAIN_X4;
      wr(A_STEP, {16'h0, v});
      rd_chk(A_STEP, {16'h0, v}); // read after write
      settle();
      check(last_step_enable, k[0]); // step enable
      check(last_step_gain_factor, g); // gain decode
      check(last_step_neg_ext_seven, k < 8); // negative input
      check(last_step_pos_ext, k < 8 ? 32'h1 << k : 32'h0); // external input
      check({last_step_pos_internal, last_step_internal_src}, {k > 7, // internal source
        k == 8 ? 2'h0 : k == 9 ? 2'h1 : k == 11 ? 2'h2 : 2'h3});
      check(last_step_neg_auto, k > 7); // automatic negative
    end
    rd_chk(32'h00000320, {14'h0, 1'b1, 1'b1, 1'b0, 1'b1, 2'h3, GAIN_X4, 1'b0, 8'h00});
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    wait_ready();
    rd_chk(A_STEP, 32'h000F); // value after second reset
    rd_chk(32'h00000320, {14'h0, 1'b0, 1'b1, 1'b0, 1'b1, 2'h3, GAIN_X1, 1'b0, 8'h00});
    end_of_test();
  end
endmodule
`default_nettype wire
